// *** thvf_pkg.sv ***
/*
  constants, field positions and carrier types of the text and wide-cell
  video fetch block.
  assumes a 100 MHz system clock and a timing chip that steps its refresh
  and row addresses once per character tick of this block.
*/
`default_nettype none

package thvf_pkg;

  // =========================================================
  // clock and time
  localparam int CLK_NS = 10;
  localparam int CPU_NS = 200;
  localparam int CPU_CYC = (CPU_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_NS = 200;
  localparam int DISP_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_TO_CAS = 4;
  localparam int LINE_US = 64;
  localparam int REFRESH_PER_LINE = 15;

  // =========================================================
  // character cell geometry
  localparam int DOT_DIV = 5;
  localparam int TEXT_DOTS = 10;
  localparam int WIDE_DOTS = 16;
  localparam logic [6:0] TEXT_CELL = 7'(TEXT_DOTS * DOT_DIV);
  localparam logic [6:0] WIDE_CELL = 7'(WIDE_DOTS * DOT_DIV);

  // =========================================================
  // screen buffer word and glyph word
  localparam int SB_DEPTH = 2048;
  localparam int SB_AW = 11;
  localparam int PTR_W = 11;
  localparam int ATTR_REV = 15;
  localparam int ATTR_LOW = 14;
  localparam int ATTR_UL = 13;
  localparam int ATTR_ND = 12;
  localparam int ATTR_SPARE = 11;
  localparam int GLYPH_UL_BIT = 15;

  // =========================================================
  // refresh address lines with special use
  localparam int MODE_BIT = 13;
  localparam int BANK_BIT = 12;

  // =========================================================
  // register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PEN = 4'h2;
  localparam logic [3:0] REG_REFRESH = 4'h3;
  localparam logic [5:0] CTRL_RST = 6'h07;
  localparam int BRIGHT_LSB = 0;
  localparam int CONTRAST_LSB = 3;

  // =========================================================
  // carriers
  typedef struct packed {
    logic reverse;
    logic low_int;
    logic underline;
    logic nondisp;
    logic spare;
  } thvf_attr_s;

  typedef struct packed {
    logic ras;
    logic cas;
    logic we;
    logic [7:0] addr;
  } thvf_dram_s;

  typedef enum logic [1:0] {
    CPU_IDLE,
    CPU_WAIT,
    CPU_ACCESS,
    CPU_DONE
  } thvf_cpu_e;

  typedef enum logic [1:0] {
    SLOT_IDLE,
    SLOT_FONT,
    SLOT_REFRESH
  } thvf_slot_e;

endpackage

`default_nettype wire

// *** thvf_sync_reg.sv ***
/*
  character sync register: a word that is loaded on each character tick.
  assumes load_i is a one-cycle pulse in the mclk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none

module thvf_sync_reg #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      q_o <= '0;
    end
    else if (load_i)
    begin
      q_o <= d_i;
    end
  end

endmodule

`default_nettype wire

// *** thvf_video_fetch.sv ***
/*
  raster fetch, dot shifter, attribute stage and shared dram arbiter.
  assumes the timing chip steps refresh_addr_i and row_addr_i on each
  char_tick_o, and the processor holds cpu_req_i until cpu_ready_o.
*/
// What this block does
// - low 11 bits of screen word are glyph pointer, top five attributes
// - bit15 reverse, 14 low intensity, 13 underline, 12 nondisplay
// - screen address and address plus 0x800 hit one physical word
// - refresh reads use only 11 low refresh address lines
// - font address is bank, pointer, four row bits, muxed to 8 lines
// - glyph is 16 words, low 10 bits dots, lsb top-left
// - text: glyph bit15 with underline attribute makes line all white
// - output applies attributes and cursor, aligned through sync registers
// - wide select gives 16-dot cells using all glyph bits
// - wide mode: attributes per cell, underline has no effect
// - refresh line 13 selects wide mode, not an address
// - glyph word loads 16-bit shifter, 10 or 16 dots shifted
// - at most one display access to shared ram per character cell, none in idle cells
// - colliding processor cycle waits up to 400 ns, until the whole 200 ns access fits after the display slot
// - retrace slots drive 8 refresh bits, no cas, counter advances
// - fifteen refresh cycles per 64 us line
// - pen strobe captures current refresh address
// - three brightness bits pick eight rising levels
// - three contrast bits lower only normal intensity, zero none
// - bank low puts font at 0, high at 0x8000
`timescale 1ns/1ps
`default_nettype none

module thvf_video_fetch (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [13:0] refresh_addr_i,
  input wire logic [4:0] row_addr_i,
  input wire logic display_window_i,
  input wire logic hsync_i,
  input wire logic cursor_i,
  input wire logic pen_strobe_i,
  output logic char_tick_o,
  input wire logic cpu_req_i,
  input wire logic cpu_sb_sel_i,
  input wire logic cpu_we_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  output logic cpu_ready_o,
  output logic cpu_wait_o,
  output thvf_pkg::thvf_dram_s dram_o,
  output logic [15:0] dram_wdata_o,
  input wire logic [15:0] dram_rdata_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic video_o,
  output logic [3:0] video_level_o,
  output logic wide_cell_select_o,
  output logic font_bank_select_o
);

  // =========================================================
  // cell timing
  logic [6:0] cell_cnt_r;
  logic [6:0] cell_len;
  logic cell_last;
  logic [2:0] dot_div_r;
  logic dot_tick;
  logic wide_r;

  assign cell_len = wide_r ? thvf_pkg::WIDE_CELL : thvf_pkg::TEXT_CELL;
  assign cell_last = (cell_cnt_r == cell_len - 7'd1);
  assign dot_tick = (dot_div_r == 3'(thvf_pkg::DOT_DIV - 1));

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || cell_last)
    begin
      cell_cnt_r <= '0;
      dot_div_r <= '0;
    end
    else
    begin
      cell_cnt_r <= cell_cnt_r + 7'd1;
      dot_div_r <= dot_tick ? 3'd0 : dot_div_r + 3'd1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      char_tick_o <= 1'b0;
    end
    else
    begin
      char_tick_o <= cell_last;
    end
  end

  // =========================================================
  // mode lines and fetch stage, taken at the cell boundary
  logic bank_r;
  logic [3:0] row_r;
  logic [15:0] sb_word_r;
  logic [15:0] sb_mem [0:thvf_pkg::SB_DEPTH-1];

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wide_r <= 1'b0;
      bank_r <= 1'b0;
      row_r <= '0;
    end
    else if (cell_last)
    begin
      wide_r <= refresh_addr_i[thvf_pkg::MODE_BIT];
      bank_r <= refresh_addr_i[thvf_pkg::BANK_BIT];
      row_r <= row_addr_i[3:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (cell_last)
    begin
      sb_word_r <= sb_mem[refresh_addr_i[thvf_pkg::SB_AW-1:0]];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wide_cell_select_o <= 1'b0;
      font_bank_select_o <= 1'b0;
    end
    else
    begin
      wide_cell_select_o <= wide_r;
      font_bank_select_o <= bank_r;
    end
  end

  // =========================================================
  // character sync stages: chip signals then attributes
  logic [1:0] sync1_q;
  logic [6:0] sync2_d;
  logic [6:0] sync2_q;
  thvf_pkg::thvf_attr_s attr_w;
  logic cur_w;
  logic win_w;

  thvf_sync_reg #(
    .W(2)
  ) u_sync1 (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(cell_last),
    .d_i({cursor_i, display_window_i}),
    .q_o(sync1_q)
  );

  assign sync2_d = {sb_word_r[15:thvf_pkg::ATTR_SPARE], sync1_q};

  thvf_sync_reg #(
    .W(7)
  ) u_sync2 (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(cell_last),
    .d_i(sync2_d),
    .q_o(sync2_q)
  );

  assign attr_w = thvf_pkg::thvf_attr_s'(sync2_q[6:2]);
  assign cur_w = sync2_q[1];
  assign win_w = sync2_q[0];

  // =========================================================
  // display slot choice and refresh budget
  thvf_pkg::thvf_slot_e slot_r;
  logic [3:0] line_ref_r;
  logic hsync_d_r;
  logic [7:0] ref_cnt_r;
  logic slot_on;
  logic [15:0] font_addr;

  assign font_addr = {bank_r, sb_word_r[thvf_pkg::PTR_W-1:0], row_r};
  assign slot_on = (slot_r != thvf_pkg::SLOT_IDLE) &&
                   (cell_cnt_r < 7'(thvf_pkg::DISP_CYC));

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      slot_r <= thvf_pkg::SLOT_IDLE;
    end
    else if (cell_last)
    begin
      if (sync1_q[0])
      begin
        slot_r <= thvf_pkg::SLOT_FONT;
      end
      else if (line_ref_r < 4'(thvf_pkg::REFRESH_PER_LINE))
      begin
        slot_r <= thvf_pkg::SLOT_REFRESH;
      end
      else
      begin
        slot_r <= thvf_pkg::SLOT_IDLE;
      end
    end
  end

  logic slot_end;
  assign slot_end = (cell_cnt_r == 7'(thvf_pkg::DISP_CYC - 1));

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      hsync_d_r <= 1'b0;
      line_ref_r <= '0;
      ref_cnt_r <= '0;
    end
    else
    begin
      hsync_d_r <= hsync_i;
      if (hsync_i && !hsync_d_r)
      begin
        line_ref_r <= '0;
      end
      else if (slot_r == thvf_pkg::SLOT_REFRESH && slot_end)
      begin
        line_ref_r <= line_ref_r + 4'd1;
      end
      if (slot_r == thvf_pkg::SLOT_REFRESH && slot_end)
      begin
        ref_cnt_r <= ref_cnt_r + 8'd1;
      end
    end
  end

  // =========================================================
  // processor side arbiter
  thvf_pkg::thvf_cpu_e cpu_st_r;
  logic [4:0] cpu_cnt_r;
  logic cpu_ok;

  assign cpu_ok = (cell_cnt_r >= 7'(thvf_pkg::DISP_CYC)) &&
                  ({1'b0, cell_cnt_r} + 8'(thvf_pkg::CPU_CYC) <
                   {1'b0, cell_len});

  always_ff @(posedge mclk_i)
  begin
    if (cpu_st_r == thvf_pkg::CPU_IDLE && cpu_req_i && cpu_sb_sel_i &&
        cpu_we_i)
    begin
      sb_mem[cpu_addr_i[thvf_pkg::SB_AW-1:0]] <= cpu_wdata_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cpu_st_r <= thvf_pkg::CPU_IDLE;
      cpu_cnt_r <= '0;
      cpu_ready_o <= 1'b0;
      cpu_wait_o <= 1'b0;
      cpu_rdata_o <= '0;
    end
    else
    begin
      cpu_ready_o <= 1'b0;
      case (cpu_st_r)
        thvf_pkg::CPU_IDLE:
        begin
          cpu_cnt_r <= '0;
          if (cpu_req_i && cpu_sb_sel_i)
          begin
            cpu_rdata_o <= sb_mem[cpu_addr_i[thvf_pkg::SB_AW-1:0]];
            cpu_ready_o <= 1'b1;
            cpu_st_r <= thvf_pkg::CPU_DONE;
          end
          else if (cpu_req_i && cpu_ok)
          begin
            cpu_st_r <= thvf_pkg::CPU_ACCESS;
          end
          else if (cpu_req_i)
          begin
            cpu_wait_o <= 1'b1;
            cpu_st_r <= thvf_pkg::CPU_WAIT;
          end
        end
        thvf_pkg::CPU_WAIT:
        begin
          if (cpu_ok)
          begin
            cpu_wait_o <= 1'b0;
            cpu_st_r <= thvf_pkg::CPU_ACCESS;
          end
        end
        thvf_pkg::CPU_ACCESS:
        begin
          cpu_cnt_r <= cpu_cnt_r + 5'd1;
          if (cpu_cnt_r == 5'(thvf_pkg::CPU_CYC - 2))
          begin
            cpu_rdata_o <= dram_rdata_i;
          end
          if (cpu_cnt_r == 5'(thvf_pkg::CPU_CYC - 1))
          begin
            cpu_ready_o <= 1'b1;
            cpu_st_r <= thvf_pkg::CPU_DONE;
          end
        end
        thvf_pkg::CPU_DONE:
        begin
          cpu_st_r <= thvf_pkg::CPU_IDLE;
        end
        default:
        begin
          cpu_st_r <= thvf_pkg::CPU_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // dram pins: display slot first, processor in the rest of the cell
  logic [15:0] glyph_r;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      dram_o <= '0;
      dram_wdata_o <= '0;
    end
    else if (slot_on)
    begin
      dram_o.we <= 1'b0;
      dram_o.ras <= !slot_end;
      if (slot_r == thvf_pkg::SLOT_REFRESH)
      begin
        dram_o.cas <= 1'b0;
        dram_o.addr <= ref_cnt_r;
      end
      else if (cell_cnt_r < 7'(thvf_pkg::RAS_TO_CAS))
      begin
        dram_o.cas <= 1'b0;
        dram_o.addr <= font_addr[15:8];
      end
      else
      begin
        dram_o.cas <= !slot_end;
        dram_o.addr <= font_addr[7:0];
      end
    end
    else if (cpu_st_r == thvf_pkg::CPU_ACCESS)
    begin
      dram_o.ras <= (cpu_cnt_r != 5'(thvf_pkg::CPU_CYC - 1));
      dram_o.we <= cpu_we_i;
      dram_wdata_o <= cpu_wdata_i;
      if (cpu_cnt_r < 5'(thvf_pkg::RAS_TO_CAS))
      begin
        dram_o.cas <= 1'b0;
        dram_o.addr <= cpu_addr_i[15:8];
      end
      else
      begin
        dram_o.cas <= (cpu_cnt_r != 5'(thvf_pkg::CPU_CYC - 1));
        dram_o.addr <= cpu_addr_i[7:0];
      end
    end
    else
    begin
      dram_o <= '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      glyph_r <= '0;
    end
    else if (slot_r == thvf_pkg::SLOT_FONT &&
             cell_cnt_r == 7'(thvf_pkg::DISP_CYC - 2))
    begin
      glyph_r <= dram_rdata_i;
    end
    else if (slot_r != thvf_pkg::SLOT_FONT && cell_last)
    begin
      glyph_r <= '0;
    end
  end

  // =========================================================
  // dot shifter
  logic [15:0] shift_r;
  logic ul_line_r;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      shift_r <= '0;
      ul_line_r <= 1'b0;
    end
    else if (cell_last)
    begin
      shift_r <= glyph_r;
      ul_line_r <= glyph_r[thvf_pkg::GLYPH_UL_BIT] &&
                   sb_word_r[thvf_pkg::ATTR_UL] &&
                   !refresh_addr_i[thvf_pkg::MODE_BIT];
    end
    else if (dot_tick)
    begin
      shift_r <= {1'b0, shift_r[15:1]};
    end
  end

  // =========================================================
  // video output stage
  logic [5:0] ctrl_r;
  logic [3:0] hi_level;
  logic [3:0] norm_level;
  logic pix;

  assign hi_level = {1'b1, ctrl_r[thvf_pkg::BRIGHT_LSB +: 3]};
  assign norm_level = hi_level - {1'b0, ctrl_r[thvf_pkg::CONTRAST_LSB +: 3]};

  always_comb
  begin
    pix = ul_line_r ? 1'b1 : shift_r[0];
    pix = pix && !attr_w.nondisp;
    pix = pix ^ attr_w.reverse;
    pix = pix ^ cur_w;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      video_o <= 1'b0;
      video_level_o <= '0;
    end
    else
    begin
      video_o <= win_w && pix;
      video_level_o <= attr_w.low_int ? norm_level : hi_level;
    end
  end

  // =========================================================
  // light pen capture
  logic [13:0] pen_r;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      pen_r <= '0;
    end
    else if (pen_strobe_i)
    begin
      pen_r <= refresh_addr_i;
    end
  end

  // =========================================================
  // register port
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_r <= thvf_pkg::CTRL_RST;
    end
    else if (reg_wr_i && reg_addr_i == thvf_pkg::REG_CTRL)
    begin
      ctrl_r <= reg_wdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        thvf_pkg::REG_CTRL: reg_rdata_o <= {10'h000, ctrl_r};
        thvf_pkg::REG_STATUS:
          reg_rdata_o <= {10'h000, wide_r, bank_r, line_ref_r};
        thvf_pkg::REG_PEN: reg_rdata_o <= {2'b00, pen_r};
        thvf_pkg::REG_REFRESH: reg_rdata_o <= {8'h00, ref_cnt_r};
        default: reg_rdata_o <= '0;
      endcase
    end
    else
    begin
      reg_rdata_o <= '0;
    end
  end

endmodule

`default_nettype wire

// *** thvf_dram_model.sv ***
/*
  partner model: word store behind the multiplexed dram port.
  assumes active-high strobes, the row address on the rise of ras and the
  column address while cas is high.
*/
`timescale 1ns/1ps
`default_nettype none

module thvf_dram_model (
  input wire logic mclk_i,
  input wire thvf_pkg::thvf_dram_s dram_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:65535];
  logic [7:0] row_r;
  logic ras_q;
  logic [15:0] last_r;

  // =========================================================
  // row latch and write port
  always @(posedge mclk_i)
  begin
    ras_q <= dram_i.ras;
    if (dram_i.ras && !ras_q)
      row_r <= dram_i.addr;
    if (dram_i.cas && dram_i.we)
      mem[{row_r, dram_i.addr}] <= wdata_i;
    if (dram_i.cas)
      last_r <= rdata_o;
  end

  // released lines show the inverse of the last word, never a hold
  assign rdata_o = dram_i.cas ? mem[{row_r, dram_i.addr}] : ~last_r;
endmodule

`default_nettype wire

// *** thvf_video_fetch_properties.sv ***
/*
  port assertions of the video fetch block.
  assumes binding to thvf_video_fetch, one clock and a sync reset.
*/
`timescale 1ns/1ps
`default_nettype none

module thvf_video_fetch_properties (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [13:0] refresh_addr_i,
  input wire logic pen_strobe_i,
  input wire logic char_tick_o,
  input wire logic cpu_req_i,
  input wire logic cpu_sb_sel_i,
  input wire logic cpu_ready_o,
  input wire logic cpu_wait_o,
  input wire thvf_pkg::thvf_dram_s dram_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // =========================================================
  // cycles since the last character tick
  logic [6:0] gap_r;
  logic started_r;
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || char_tick_o)
      gap_r <= 7'h00;
    else
      gap_r <= gap_r + 7'h01;
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      started_r <= 1'b0;
    else if (char_tick_o)
      started_r <= 1'b1;
  end

  // =========================================================
  // properties
  property p_cell_len;
    char_tick_o && started_r |-> gap_r == thvf_pkg::TEXT_CELL - 7'h01
      || gap_r == thvf_pkg::WIDE_CELL - 7'h01;
  endproperty
  a_cell_len: assert property (p_cell_len)
    else $error("cell length off");
  property p_slot_len;
    $rose(dram_o.ras) |-> dram_o.ras [*8];
  endproperty
  a_slot_len: assert property (p_slot_len)
    else $error("dram slot too short");
  property p_row_first;
    $rose(dram_o.ras) |-> !dram_o.cas [*4];
  endproperty
  a_row_first: assert property (p_row_first)
    else $error("cas too early after ras");
  property p_cas_in_ras;
    dram_o.cas |-> dram_o.ras;
  endproperty
  a_cas_in_ras: assert property (p_cas_in_ras)
    else $error("cas without ras");
  property p_ready_pulse;
    cpu_ready_o |=> !cpu_ready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_sb_fast;
    $rose(cpu_req_i) && cpu_sb_sel_i |=> cpu_ready_o;
  endproperty
  a_sb_fast: assert property (p_sb_fast)
    else $error("screen access not answered next cycle");
  property p_dram_bound;
    $rose(cpu_req_i) && !cpu_sb_sel_i |-> ##[19:130] cpu_ready_o;
  endproperty
  a_dram_bound: assert property (p_dram_bound)
    else $error("dram access not answered in time");
  property p_rd_quiet;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside read answer");
  property p_pen;
    pen_strobe_i ##1 (reg_rd_i && !pen_strobe_i
      && reg_addr_i == thvf_pkg::REG_PEN)
      |=> reg_rdata_o == {2'b00, $past(refresh_addr_i, 2)};
  endproperty
  a_pen: assert property (p_pen)
    else $error("pen register wrong");

  c_wait: cover property (cpu_wait_o);
  c_write: cover property (dram_o.cas && dram_o.we);
  c_pen: cover property (pen_strobe_i);
endmodule

`default_nettype wire

// *** thvf_video_fetch_tb.sv ***
/*
  self-checking bench of the video fetch block with a dram partner.
  assumes the design, package, partner and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module thvf_video_fetch_tb;
  logic mclk_i, sys_rst_i, display_window_i, hsync_i, cursor_i;
  logic pen_strobe_i, cpu_req_i, cpu_sb_sel_i, cpu_we_i, reg_wr_i, reg_rd_i;
  logic char_tick_o, cpu_ready_o, cpu_wait_o, video_o;
  logic wide_cell_select_o, font_bank_select_o, wait_seen, cas_seen;
  logic [13:0] refresh_addr_i;
  logic [4:0] row_addr_i;
  logic [15:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, dram_wdata_o;
  logic [15:0] dram_rdata_i, reg_rdata_o;
  logic [3:0] reg_addr_i, video_level_o;
  logic [7:0] reg_wdata_i;
  thvf_pkg::thvf_dram_s dram_o;
  int n_errors, checks, cyc;

  thvf_video_fetch i_dut (.mclk_i, .sys_rst_i, .refresh_addr_i, .row_addr_i,
    .display_window_i, .hsync_i, .cursor_i, .pen_strobe_i, .char_tick_o,
    .cpu_req_i, .cpu_sb_sel_i, .cpu_we_i, .cpu_addr_i, .cpu_wdata_i,
    .cpu_rdata_o, .cpu_ready_o, .cpu_wait_o, .dram_o, .dram_wdata_o,
    .dram_rdata_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .video_o, .video_level_o, .wide_cell_select_o,
    .font_bank_select_o);
  thvf_dram_model i_dram (.mclk_i, .dram_i(dram_o), .wdata_i(dram_wdata_o),
    .rdata_o(dram_rdata_i));

  // =========================================================
  // clock, monitors and timeout
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cpu_wait_o === 1'b1)
      wait_seen = 1'b1;
    if (dram_o.cas === 1'b1)
      cas_seen = 1'b1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  // =========================================================
  // shared tasks
  task end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks = checks + 1;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_errors = n_errors + 1;
    end
  endtask
  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task reg_rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
    @(posedge mclk_i);
  endtask
  task cpu(input logic sb, input logic we, input logic [15:0] a,
    input logic [15:0] w, output logic [15:0] r);
    int n;
    n = 0;
    cpu_req_i <= 1'b1;
    cpu_sb_sel_i <= sb;
    cpu_we_i <= we;
    cpu_addr_i <= a;
    cpu_wdata_i <= w;
    do
    begin
      @(posedge mclk_i);
      n = n + 1;
    end while (cpu_ready_o !== 1'b1 && n < 200);
    r = cpu_rdata_o;
    if (n >= 200)
      chk("cpu ready", 16'h0001, 16'h0000);
    cpu_req_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task wait_tick;
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n = n + 1;
    end while (char_tick_o !== 1'b1 && n < 200);
    if (n >= 200)
      chk("char tick", 16'h0001, 16'h0000);
  endtask

  // =========================================================
  // scenarios
  task t_regs;
    logic [15:0] d;
    reg_rd(thvf_pkg::REG_CTRL, d);
    chk("ctrl reset", 16'h0007, d);
    reg_wr(thvf_pkg::REG_CTRL, 8'hFF);
    reg_rd(thvf_pkg::REG_CTRL, d);
    chk("ctrl width", 16'h003F, d);
    reg_rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    reg_wr(thvf_pkg::REG_CTRL, 8'h1D);
  endtask
  task t_sb;
    logic [15:0] r;
    cpu(1'b1, 1'b1, 16'h0005, 16'hA5C3, r);
    cpu(1'b1, 1'b0, 16'h0805, 16'h0000, r);
    chk("screen mirror", 16'hA5C3, r);
  endtask
  task t_dram;
    logic [15:0] r;
    int i;
    wait_seen = 1'b0;
    for (i = 0; i < 6; i++)
      cpu(1'b0, 1'b1, 16'h4000 + 16'(i), 16'h1111 * 16'(i + 1), r);
    for (i = 0; i < 6; i++)
    begin
      cpu(1'b0, 1'b0, 16'h4000 + 16'(i), 16'h0000, r);
      chk("dram word", 16'h1111 * 16'(i + 1), r);
    end
    chk("cpu waited", 16'h0001, {15'h0000, wait_seen});
  endtask
  task t_cell(input logic [10:0] idx, input logic [4:0] attr,
    input logic [10:0] ptr, input logic [3:0] row, input logic bank,
    input logic wide, input logic cur, input logic [15:0] g);
    logic [15:0] r;
    logic d;
    int k;
    cpu(1'b1, 1'b1, {5'h00, idx}, {attr, ptr}, r);
    cpu(1'b0, 1'b1, {bank, ptr, row}, g, r);
    refresh_addr_i <= {wide, bank, 1'b1, idx};
    row_addr_i <= {1'b0, row};
    cursor_i <= cur;
    display_window_i <= 1'b1;
    repeat (4) wait_tick();
    chk("wide select", {15'h0000, wide}, {15'h0000, wide_cell_select_o});
    chk("bank select", {15'h0000, bank}, {15'h0000, font_bank_select_o});
    for (k = 0; k < (wide ? 16 : 10); k++)
    begin
      repeat (k == 0 ? 3 : 5) @(negedge mclk_i);
      d = g[k];
      if (!wide && g[15] && attr[2])
        d = 1'b1;
      if (attr[1])
        d = 1'b0;
      d = d ^ attr[4] ^ cur;
      chk("dot", {15'h0000, d}, {15'h0000, video_o});
      if (d)
        chk("level", attr[3] ? 16'h000A : 16'h000D, {12'h000, video_level_o});
    end
    @(posedge mclk_i);
  endtask
  task t_refresh;
    logic [15:0] a, b;
    reg_rd(thvf_pkg::REG_REFRESH, a);
    cas_seen = 1'b0;
    display_window_i <= 1'b0;
    hsync_i <= 1'b1;
    @(posedge mclk_i);
    hsync_i <= 1'b0;
    repeat (2) wait_tick();
    cas_seen = 1'b0;
    repeat (8'h3A - 8'h01) wait_tick();
    @(posedge mclk_i);
    reg_rd(thvf_pkg::REG_REFRESH, b);
    chk("refresh advance", {8'h00, a[7:0] + 8'h0F}, b);
    chk("ras only", 16'h0000, {15'h0000, cas_seen});
    reg_rd(thvf_pkg::REG_STATUS, b);
    chk("line refreshes", 16'h000F, {12'h000, b[3:0]});
  endtask
  task t_pen;
    logic [15:0] r;
    refresh_addr_i <= 14'h2ABC;
    pen_strobe_i <= 1'b1;
    @(posedge mclk_i);
    pen_strobe_i <= 1'b0;
    reg_rd(thvf_pkg::REG_PEN, r);
    chk("pen", 16'h2ABC, r);
    chk("pen position", 16'h0ABC, r & 16'h0FFF);
  endtask

  // =========================================================
  // main sequence
  initial
  begin
    {sys_rst_i, display_window_i, hsync_i, cursor_i, pen_strobe_i} = 5'h10;
    {cpu_req_i, cpu_sb_sel_i, cpu_we_i, reg_wr_i, reg_rd_i} = 5'h00;
    {refresh_addr_i, row_addr_i, reg_addr_i, reg_wdata_i} = '0;
    {cpu_addr_i, cpu_wdata_i, wait_seen, cas_seen} = '0;
    {n_errors, checks, cyc} = '0;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_sb();
    t_dram();
    t_cell(11'h010, 5'h00, 11'h123, 4'h3, 1'b0, 1'b0, 1'b0, 16'h0155);
    t_cell(11'h011, 5'h04, 11'h124, 4'h5, 1'b0, 1'b0, 1'b0, 16'h8003);
    t_cell(11'h012, 5'h18, 11'h7FF, 4'hF, 1'b0, 1'b0, 1'b0, 16'h0281);
    t_cell(11'h7FF, 5'h02, 11'h001, 4'h0, 1'b0, 1'b0, 1'b1, 16'h03FF);
    t_cell(11'h013, 5'h05, 11'h3C5, 4'h9, 1'b1, 1'b1, 1'b0, 16'h8F0F);
    t_refresh();
    t_pen();
    end_of_test();
  end
endmodule

bind thvf_video_fetch thvf_video_fetch_properties i_props (.mclk_i,
  .sys_rst_i, .refresh_addr_i, .pen_strobe_i, .char_tick_o, .cpu_req_i,
  .cpu_sb_sel_i, .cpu_ready_o, .cpu_wait_o, .dram_o, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o);

`default_nettype wire
